// File: inc/bfw_regs.svh
// Offsets, field positions and reset values of the forwarding window registers
`ifndef BFW_REGS_SVH
`define BFW_REGS_SVH
`define BFW_OFF_MEM       8'h20
`define BFW_OFF_PREF_LOW  8'h24
`define BFW_OFF_PREF_BOT  8'h28
`define BFW_OFF_PREF_TOP  8'h2c
`define BFW_OFF_IO_HIGH   8'h30
`define BFW_BOT_LSB       4
`define BFW_BOT_MSB       15
`define BFW_TOP_LSB       20
`define BFW_TOP_MSB       31
`define BFW_IND_BOT_LSB   0
`define BFW_IND_BOT_MSB   3
`define BFW_IND_TOP_LSB   16
`define BFW_IND_TOP_MSB   19
`define BFW_IND_64BIT     4'h1
`define BFW_IO_BOT_LSB    0
`define BFW_IO_BOT_MSB    15
`define BFW_IO_TOP_LSB    16
`define BFW_IO_TOP_MSB    31
`define BFW_RST_FIELD12   12'h000
`define BFW_RST_WORD32    32'h00000000
`define BFW_RST_HALF16    16'h0000
`define BFW_LOW_ZERO      20'h00000
`define BFW_LOW_ONES      20'hfffff
`define BFW_RESP_OKAY     2'h0
`define BFW_RESP_SLVERR   2'h2
`endif

// File: inc/bfw_pkg.sv
// Types of the bridge forwarding window register block
package bfw_pkg;
    typedef struct packed {
        logic        awHeld;
        logic [7:0]  awAddr;
        logic        wHeld;
        logic [31:0] wData;
        logic [3:0]  wStrb;
        logic        bValid;
        logic [1:0]  bResp;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
        logic [11:0] memBottom;
        logic [11:0] memTop;
        logic [11:0] prefBottomLow;
        logic [11:0] prefTopLow;
        logic [31:0] prefBottomHigh;
        logic [31:0] prefTopHigh;
        logic [15:0] ioBottomHigh;
        logic [15:0] ioTopHigh;
        logic        hitValid;
        logic        memHit;
        logic        prefHit;
    } bfw_state_t;
endpackage : bfw_pkg

// File: src/bfw_window_regs.sv
// Forwarding window registers with AXI4-Lite access and window hit decode
`timescale 1ns/10ps
`include "bfw_regs.svh"

module bfw_window_regs (
    input  wire logic        clk,
    input  wire logic        reset_n,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Routing logic lookup
    input  wire logic        lookupValid,
    input  wire logic [63:0] lookupAddr,
    output logic             hitValid,
    output logic             memHit,
    output logic             prefHit,
    // Window bounds for the routing logic
    output logic [31:0]      memBottomAddr,
    output logic [31:0]      memTopAddr,
    output logic [63:0]      prefBottomAddr,
    output logic [63:0]      prefTopAddr,
    output logic [15:0]      ioBottomHigh,
    output logic [15:0]      ioTopHigh
);

    bfw_pkg::bfw_state_t state;
    bfw_pkg::bfw_state_t next_state;

    logic        writeFire;
    logic [31:0] writeMask;
    logic [31:0] writeOld;
    logic [31:0] writeNew;
    logic        writeMapped;
    logic [31:0] readWord;
    logic        readMapped;
    logic [31:0] memBottomFull;
    logic [31:0] memTopFull;
    logic [63:0] prefBottomFull;
    logic [63:0] prefTopFull;
    // Handshake and lookup compare terms
    logic        awTake;
    logic        wTake;
    logic        arTake;
    logic        bDone;
    logic        rDone;
    logic        upperClear;
    logic        memAboveBottom;
    logic        memBelowTop;
    logic        prefAboveBottom;
    logic        prefBelowTop;

    // Protection bits carry no meaning here; all accesses are treated alike
    // Folded to one bit only so that the ports keep a reader
    logic        unusedProt;
    assign unusedProt = ^{s_axi_awprot, s_axi_arprot};

    // Register image of a word as software sees it
    // Reserved bits and unmapped offsets read as zero
    function automatic logic [31:0] bfw_image(input bfw_pkg::bfw_state_t st,
                                             input logic [7:0] addr);
        logic [31:0] w;
        w = 32'h00000000;
        unique case (addr)
            `BFW_OFF_MEM: begin
                w[`BFW_BOT_MSB:`BFW_BOT_LSB] = st.memBottom;
                w[`BFW_TOP_MSB:`BFW_TOP_LSB] = st.memTop;
            end
            `BFW_OFF_PREF_LOW: begin
                w[`BFW_IND_BOT_MSB:`BFW_IND_BOT_LSB] = `BFW_IND_64BIT;
                w[`BFW_BOT_MSB:`BFW_BOT_LSB] = st.prefBottomLow;
                w[`BFW_IND_TOP_MSB:`BFW_IND_TOP_LSB] = `BFW_IND_64BIT;
                w[`BFW_TOP_MSB:`BFW_TOP_LSB] = st.prefTopLow;
            end
            `BFW_OFF_PREF_BOT: begin
                w = st.prefBottomHigh;
            end
            `BFW_OFF_PREF_TOP: begin
                w = st.prefTopHigh;
            end
            `BFW_OFF_IO_HIGH: begin
                w[`BFW_IO_BOT_MSB:`BFW_IO_BOT_LSB] = st.ioBottomHigh;
                w[`BFW_IO_TOP_MSB:`BFW_IO_TOP_LSB] = st.ioTopHigh;
            end
            default: begin
                w = 32'h00000000;
            end
        endcase
        return w;
    endfunction : bfw_image

    // Address decode shared by both channels
    // Bits 1:0 take part, so only aligned word offsets map
    function automatic logic bfw_mapped(input logic [7:0] addr);
        return (addr == `BFW_OFF_MEM) || (addr == `BFW_OFF_PREF_LOW) ||
               (addr == `BFW_OFF_PREF_BOT) || (addr == `BFW_OFF_PREF_TOP) ||
               (addr == `BFW_OFF_IO_HIGH);
    endfunction : bfw_mapped

    // Channel ready terms; a pending response blocks new writes
    // One holding stage per channel, so a second write cannot queue behind the first
    assign s_axi_awready = !state.awHeld && !state.bValid;
    assign s_axi_wready  = !state.wHeld && !state.bValid;
    assign s_axi_arready = !state.rValid;

    // Handshakes completed at this edge
    assign awTake = s_axi_awvalid && s_axi_awready;
    assign wTake  = s_axi_wvalid && s_axi_wready;
    assign arTake = s_axi_arvalid && s_axi_arready;
    assign bDone  = state.bValid && s_axi_bready;
    assign rDone  = state.rValid && s_axi_rready;

    // A write completes once both address and data are in hand
    assign writeFire   = state.awHeld && state.wHeld && !state.bValid;
    assign writeMapped = bfw_mapped(state.awAddr);
    assign writeOld    = bfw_image(state, state.awAddr);
    assign writeNew    = (writeOld & ~writeMask) | (state.wData & writeMask);

    // Byte strobes widened to a bit mask; unstrobed bytes keep their contents
    for (genvar lane = 0; lane < 4; lane++) begin : gen_strobe_lane
        assign writeMask[8*lane +: 8] = {8{state.wStrb[lane]}};
    end

    // Read data is captured at address acceptance
    // A write landing after that edge is not seen by this read
    assign readWord   = bfw_image(state, s_axi_araddr);
    assign readMapped = bfw_mapped(s_axi_araddr);

    // Full window bounds; low bits implied, never stored
    assign memBottomFull  = {state.memBottom, `BFW_LOW_ZERO};
    assign memTopFull     = {state.memTop, `BFW_LOW_ONES};
    assign prefBottomFull = {state.prefBottomHigh, state.prefBottomLow, `BFW_LOW_ZERO};
    assign prefTopFull    = {state.prefTopHigh, state.prefTopLow, `BFW_LOW_ONES};

    // Bound compares of the lookup address, inclusive at both ends
    // Whole-word compares; the implied low bits make the ends exact
    assign upperClear      = lookupAddr[63:32] == 32'h00000000;
    assign memAboveBottom  = lookupAddr[31:0] >= memBottomFull;
    assign memBelowTop     = lookupAddr[31:0] <= memTopFull;
    assign prefAboveBottom = lookupAddr >= prefBottomFull;
    assign prefBelowTop    = lookupAddr <= prefTopFull;

    // Next state of the bus slave, registers and lookup
    // Every field starts from its present value, so no path leaves one unassigned
    always_comb begin
        next_state = state;

        // Write address channel
        if (awTake) begin
            next_state.awHeld = 1'b1;
            next_state.awAddr = s_axi_awaddr;
        end

        // Write data channel, taken in either order with the address
        if (wTake) begin
            next_state.wHeld = 1'b1;
            next_state.wData = s_axi_wdata;
            next_state.wStrb = s_axi_wstrb;
        end

        // Register update; only writable fields take the merged word
        // Strobes merge with the present image before the fields are cut out
        if (writeFire) begin
            next_state.awHeld = 1'b0;
            next_state.wHeld  = 1'b0;
            next_state.bValid = 1'b1;
            next_state.bResp  = writeMapped ? `BFW_RESP_OKAY : `BFW_RESP_SLVERR;
            unique case (state.awAddr)
                `BFW_OFF_MEM: begin
                    next_state.memBottom = writeNew[`BFW_BOT_MSB:`BFW_BOT_LSB];
                    next_state.memTop    = writeNew[`BFW_TOP_MSB:`BFW_TOP_LSB];
                end
                `BFW_OFF_PREF_LOW: begin
                    // Indicator nibbles are not stored, so writes cannot reach them
                    next_state.prefBottomLow = writeNew[`BFW_BOT_MSB:`BFW_BOT_LSB];
                    next_state.prefTopLow    = writeNew[`BFW_TOP_MSB:`BFW_TOP_LSB];
                end
                `BFW_OFF_PREF_BOT: begin
                    next_state.prefBottomHigh = writeNew;
                end
                `BFW_OFF_PREF_TOP: begin
                    next_state.prefTopHigh = writeNew;
                end
                `BFW_OFF_IO_HIGH: begin
                    next_state.ioBottomHigh = writeNew[`BFW_IO_BOT_MSB:`BFW_IO_BOT_LSB];
                    next_state.ioTopHigh    = writeNew[`BFW_IO_TOP_MSB:`BFW_IO_TOP_LSB];
                end
                default: begin
                    // Unmapped write leaves every register alone
                    next_state.bResp = `BFW_RESP_SLVERR;
                end
            endcase
        end

        // Write response handshake
        // The response waits as long as the master does; there is no timeout
        if (bDone) begin
            next_state.bValid = 1'b0;
        end

        // Read channel; read holds until rready
        // arready is low while rvalid stands, so a new read starts a cycle later
        if (arTake) begin
            next_state.rValid = 1'b1;
            next_state.rData  = readWord;
            next_state.rResp  = readMapped ? `BFW_RESP_OKAY : `BFW_RESP_SLVERR;
        end else if (rDone) begin
            next_state.rValid = 1'b0;
        end

        // Window lookup, one cycle after the request
        // Registered so the routing logic sees results free of input glitches
        next_state.hitValid = lookupValid;
        if (lookupValid) begin
            // Non-prefetchable window is 32-bit, upper address must be zero
            next_state.memHit  = upperClear && memAboveBottom && memBelowTop;
            next_state.prefHit = prefAboveBottom && prefBelowTop;
        end else begin
            next_state.memHit  = 1'b0;
            next_state.prefHit = 1'b0;
        end
    end

    // All state in one register; fields reset to their defined values
    // Handshake flags clear to zero so the bus comes up idle
    // With both fields zero the memory window still spans the first 1 MB
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state                <= '0;
            state.bResp          <= `BFW_RESP_OKAY;
            state.rResp          <= `BFW_RESP_OKAY;
            state.memBottom      <= `BFW_RST_FIELD12;
            state.memTop         <= `BFW_RST_FIELD12;
            state.prefBottomLow  <= `BFW_RST_FIELD12;
            state.prefTopLow     <= `BFW_RST_FIELD12;
            state.prefBottomHigh <= `BFW_RST_WORD32;
            state.prefTopHigh    <= `BFW_RST_WORD32;
            state.ioBottomHigh   <= `BFW_RST_HALF16;
            state.ioTopHigh      <= `BFW_RST_HALF16;
        end else begin
            state <= next_state;
        end
    end

    // Bus outputs straight from flip-flops
    // No path from a bus input reaches these outputs in the same cycle
    assign s_axi_bvalid = state.bValid;
    assign s_axi_bresp  = state.bResp;
    assign s_axi_rvalid = state.rValid;
    assign s_axi_rdata  = state.rData;
    assign s_axi_rresp  = state.rResp;

    // Lookup results
    // Hits stand for one cycle, matching the single-cycle request
    assign hitValid = state.hitValid;
    assign memHit   = state.memHit;
    assign prefHit  = state.prefHit;

    // Bounds to the routing logic; an empty window has top below bottom
    // Both ends are inclusive, so a one-megabyte window has equal fields
    assign memBottomAddr  = memBottomFull;
    assign memTopAddr     = memTopFull;
    assign prefBottomAddr = prefBottomFull;
    assign prefTopAddr    = prefTopFull;
    assign ioBottomHigh   = state.ioBottomHigh;
    assign ioTopHigh      = state.ioTopHigh;

endmodule : bfw_window_regs

// File: verif/bfw_window_sva.sv
// Checker of bus answers, window bounds and lookup hits
`timescale 1ns/10ps
module bfw_window_sva (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        lookupValid,
    input wire logic [63:0] lookupAddr,
    input wire logic        hitValid,
    input wire logic        memHit,
    input wire logic        prefHit,
    input wire logic [31:0] memBottomAddr,
    input wire logic [31:0] memTopAddr,
    input wire logic [63:0] prefBottomAddr,
    input wire logic [63:0] prefTopAddr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Expected hits from the bounds standing at the request edge
    logic expMem;
    logic expPref;
    assign expMem  = lookupAddr[63:32] == 32'h0 && lookupAddr[31:0] >= memBottomAddr
                     && lookupAddr[31:0] <= memTopAddr;
    assign expPref = lookupAddr >= prefBottomAddr && lookupAddr <= prefTopAddr;
    sequence wrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence indRead;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h24;
    endsequence
    sequence memRead;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h20;
    endsequence
    chk_mem_image: assert property (memRead |=>
        {s_axi_rdata[15:4], 20'h0} == $past(memBottomAddr)
        && {s_axi_rdata[31:20], 20'hfffff} == $past(memTopAddr)
        && s_axi_rdata[3:0] == 4'h0 && s_axi_rdata[19:16] == 4'h0)
        else $error("memory image wrong");
    chk_mem_bounds: assert property (memBottomAddr[19:0] == 20'h0
        && memTopAddr[19:0] == 20'hfffff) else $error("memory window low bits wrong");
    chk_pref_bounds: assert property (prefBottomAddr[19:0] == 20'h0
        && prefTopAddr[19:0] == 20'hfffff) else $error("prefetch window low bits wrong");
    chk_mem_hit: assert property (lookupValid |=> hitValid && memHit == $past(expMem))
        else $error("memory hit wrong");
    chk_pref_hit: assert property (lookupValid |=> prefHit == $past(expPref))
        else $error("prefetch hit wrong");
    chk_hit_idle: assert property (!lookupValid |=> !hitValid && !memHit && !prefHit)
        else $error("hit without lookup");
    chk_ind_read: assert property (indRead |=> s_axi_rvalid && s_axi_rdata[3:0] == 4'h1
        && s_axi_rdata[19:16] == 4'h1) else $error("indicator nibbles wrong");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data not held");
    chk_write_answer: assert property (wrTaken |-> ##2 s_axi_bvalid)
        else $error("write response late");
endmodule : bfw_window_sva

bind bfw_window_regs bfw_window_sva u_sva (.clk, .reset_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .lookupValid, .lookupAddr, .hitValid, .memHit,
    .prefHit, .memBottomAddr, .memTopAddr, .prefBottomAddr, .prefTopAddr);

// File: verif/bfw_route_model.sv
// Routing-side model that issues window lookups
`timescale 1ns/10ps
module bfw_route_model (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        reqValid,
    input  wire logic [63:0] reqAddr,
    output logic             lookupValid,
    output logic [63:0]      lookupAddr
);
    // Idle address toggles so a stale match cannot pass unseen
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lookupValid <= 1'b0;
            lookupAddr  <= 64'h0;
        end else begin
            lookupValid <= reqValid;
            lookupAddr  <= reqValid ? reqAddr : ~lookupAddr;
        end
    end
endmodule : bfw_route_model

// File: verif/tb.sv
// Register access and lookup bench for the forwarding window block
`timescale 1ns/10ps
`include "bfw_regs.svh"
module tb;
    logic        clk, reset_n, awValid, wValid, bReady, arValid, rReady, reqValid;
    logic        awReady, wReady, bValid, arReady, rValid, lookV, hitValid, memHit, prefHit;
    logic [7:0]  awAddr, arAddr;
    logic [31:0] wData, rData, memBot, memTop;
    logic [3:0]  wStrb;
    logic [1:0]  bResp, rResp;
    logic [63:0] reqAddr, lookA, prefBot, prefTop;
    logic [15:0] ioBot, ioTop;
    int          failCount = 0;
    int          nCompared = 0;
    localparam logic [65:0] LOOKS [10] = '{{2'b00, 64'h000fffff}, {2'b10, 64'h00100000},
        {2'b10, 64'h002fffff}, {2'b00, 64'h00300000}, {2'b00, 64'h1_00100000},
        {2'b00, 64'h1_00ffffff}, {2'b01, 64'h1_01000000}, {2'b01, 64'h1_020fffff},
        {2'b00, 64'h1_02100000}, {2'b00, 64'h2_01000000}};
    bfw_window_regs dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awAddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .lookupValid(lookV), .lookupAddr(lookA),
        .hitValid(hitValid), .memHit(memHit), .prefHit(prefHit), .memBottomAddr(memBot),
        .memTopAddr(memTop), .prefBottomAddr(prefBot), .prefTopAddr(prefTop),
        .ioBottomHigh(ioBot), .ioTopHigh(ioTop));
    bfw_route_model partner (.clk(clk), .reset_n(reset_n), .reqValid(reqValid),
        .reqAddr(reqAddr), .lookupValid(lookV), .lookupAddr(lookA));
    task automatic check(input string nm, input logic [63:0] e, input logic [63:0] g);
        nCompared++;
        if (g !== e) begin
            failCount++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    // Both channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        @(posedge clk);
        awAddr  <= a;
        wData   <= d;
        wStrb   <= s;
        awValid <= 1'b1;
        wValid  <= 1'b1;
        bReady  <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge clk);
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
            if (bValid) break;
        end
        bReady <= 1'b0;
        check("bvalid", 64'h1, {63'h0, bValid});
        check("bresp", {62'h0, er}, {62'h0, bResp});
    endtask : wr
    // rready follows rvalid by a cycle so that a held response is exercised
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        arAddr  <= a;
        arValid <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge clk);
            if (arReady) arValid <= 1'b0;
            if (rValid && rReady) break;
            if (rValid) rReady <= 1'b1;
        end
        rReady <= 1'b0;
        check("rvalid", 64'h1, {63'h0, rValid});
        check("rdata", {32'h0, e}, {32'h0, rData});
        check("rresp", {62'h0, er}, {62'h0, rResp});
    endtask : rd
    // Hits stand one cycle after the model presents the lookup
    task automatic look(input logic [65:0] t);
        @(posedge clk);
        reqAddr  <= t[63:0];
        reqValid <= 1'b1;
        @(posedge clk);
        reqValid <= 1'b0;
        @(posedge clk);
        #1;
        check("hits", {61'h0, 1'b1, t[65:64]}, {61'h0, hitValid, memHit, prefHit});
    endtask : look
    task automatic wrap_up;
        if (failCount == 0 && nCompared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        failCount++;
        wrap_up();
    end
    initial begin
        {reset_n, awValid, wValid, bReady, arValid, rReady, reqValid} = 7'h00;
        {awAddr, arAddr, wData, wStrb, reqAddr} = 116'h0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        rd(`BFW_OFF_MEM, 32'h0, 2'h0);
        rd(`BFW_OFF_PREF_LOW, 32'h00010001, 2'h0);
        rd(`BFW_OFF_PREF_BOT, 32'h0, 2'h0);
        rd(`BFW_OFF_PREF_TOP, 32'h0, 2'h0);
        rd(`BFW_OFF_IO_HIGH, 32'h0, 2'h0);
        check("memTop", 64'h000fffff, {32'h0, memTop});
        wr(`BFW_OFF_MEM, 32'hffffffff, 4'hf, 2'h0);
        rd(`BFW_OFF_MEM, 32'hfff0fff0, 2'h0);
        wr(`BFW_OFF_PREF_LOW, 32'hffffffff, 4'hf, 2'h0);
        rd(`BFW_OFF_PREF_LOW, 32'hfff1fff1, 2'h0);
        wr(`BFW_OFF_PREF_BOT, 32'h00000001, 4'hf, 2'h0);
        wr(`BFW_OFF_PREF_TOP, 32'h00000001, 4'hf, 2'h0);
        wr(`BFW_OFF_PREF_LOW, 32'h02000100, 4'hf, 2'h0);
        rd(`BFW_OFF_PREF_LOW, 32'h02010101, 2'h0);
        check("prefBot", 64'h1_01000000, prefBot);
        check("prefTop", 64'h1_020fffff, prefTop);
        wr(`BFW_OFF_MEM, 32'h00200010, 4'hf, 2'h0);
        check("memBot", 64'h00100000, {32'h0, memBot});
        check("memTop", 64'h002fffff, {32'h0, memTop});
        wr(`BFW_OFF_IO_HIGH, 32'h1234abcd, 4'h3, 2'h0);
        rd(`BFW_OFF_IO_HIGH, 32'h0000abcd, 2'h0);
        wr(`BFW_OFF_IO_HIGH, 32'h5678ffff, 4'hc, 2'h0);
        check("io", 64'h5678abcd, {32'h0, ioTop, ioBot});
        wr(8'h34, 32'hffffffff, 4'hf, 2'h2);
        rd(8'h34, 32'h0, 2'h2);
        rd(8'h22, 32'h0, 2'h2);
        for (int i = 0; i < 10; i++) look(LOOKS[i]);
        wrap_up();
    end
endmodule : tb
